// ### logic/adgc_map.svh
/*
  Register offsets, reset values and field positions of the acquisition
  digital I/O and gate control block.
  Assumes inclusion by bare name from the design file.
*/
`ifndef ADGC_MAP_SVH
`define ADGC_MAP_SVH

`define ADGC_CTRL_OFS 8'h00
`define ADGC_CMD_OFS 8'h04
`define ADGC_STAT_OFS 8'h08
`define ADGC_COUNT_OFS 8'h0c
`define ADGC_GROUP_OFS 8'h10

`define ADGC_CTRL_RST 16'h0008
`define ADGC_GROUP_RST 4'hf
`define ADGC_COUNT_RST 8'h00
`define ADGC_DIG_START_BIT 4
`define ADGC_COUNT_STEP 8'h01

`endif

// ### logic/adgc_pkg.sv
/*
  Types shared by the acquisition digital I/O and gate control block.
  Assumes nothing of its surroundings.
*/
package adgc_pkg;

  typedef struct packed {
    logic [4:0] rsvd;
    logic gate_watch;
    logic any_preset_stops_all;
    logic gate_high_when_on;
    logic gate_drop_on_preset;
    logic clear_before_start;
    logic gate_start_en;
    logic ext_start_en;
    logic open_drain;
    logic invert;
    logic stop_count_mode;
    logic status_mode;
  } adgc_ctrl_t;

  typedef struct packed {
    logic erase;
    logic stop;
    logic start;
  } adgc_cmd_t;

  typedef enum logic [1:0] {
    ADGC_IDLE = 2'b00,
    ADGC_ARMED = 2'b01,
    ADGC_CLEAR = 2'b10,
    ADGC_RUN = 2'b11
  } adgc_state_t;

endpackage

// ### logic/adgc_top.sv
/*
  Digital I/O port and gate line control for a group of up to four
  acquisition modules, with a classic Wishbone register slave.
  Assumes one 100 MHz clock, a synchronous active-high reset, and that the
  board resolves the pins from the output and active-low enable signals.
*/
// Design decisions made here: the register offsets and the Wishbone register port.
// Contract
// - Status mode shows running state on outputs
// - Invert option flips output polarity
// - Stop-count mode presents programmable 8-bit value
// - Stop-count value increments at every stop
// - Outputs are open drain by default
// - Each module has its own status bit
// - Start with external input arms, not runs
// - Active edge clears data, then starts
// - Inactive level stops; next edge restarts
// - Stop command ends input monitoring
// - Clear option erases data before start
// - Gate line high can start instead
// - Counting enabled only while gate active
// - Gate pulled low at sweep preset
// - Grouped modules start, stop, erase together
// - Any preset may stop whole group
`timescale 1ns/1ps
`include "adgc_map.svh"

module adgc_top #(
  parameter int NMOD = 4
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [7:0] DIO_I,
  output logic [7:0] DIO_O,
  output logic [7:0] DIO_OE_N,
  input wire logic GATE_I,
  output logic GATE_O,
  output logic GATE_OE_N,
  input wire logic [NMOD-1:0] PRESET_HIT,
  output logic [NMOD-1:0] RUN,
  output logic [NMOD-1:0] COUNT_EN,
  output logic [NMOD-1:0] CLEAR
);

  function automatic logic [15:0] adgc_merge(
    input logic [15:0] old,
    input logic [31:0] dat,
    input logic [3:0] sel
  );
    adgc_merge = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction

  adgc_pkg::adgc_ctrl_t ctrl_q;
  adgc_pkg::adgc_cmd_t cmd;
  adgc_pkg::adgc_state_t state_q, state_d;
  logic [NMOD-1:0] group_q, run_q, run_d;
  logic [7:0] count_q;
  logic ack_q, wb_req, wb_wr, count_wr;
  logic [31:0] rd_d;
  logic ext_s1_q, ext_s2_q, gate_s1_q, gate_s2_q;
  logic act_prev_q, trig_mode_q, drop_hold_q, drop_hold_d;
  logic trig_lvl, act_lvl, act_rise, act_fall, triggered;
  logic preset_now, stop_evt, gate_ok;
  logic [7:0] dio_val;
  logic [15:0] group_m, count_m;

  assign wb_req = WB_CYC_I & WB_STB_I & ~ack_q;
  // Narrow registers are widened to the 16-bit lane image before the byte merge
  assign group_m = adgc_merge(16'(group_q), WB_DAT_I, WB_SEL_I);
  assign count_m = adgc_merge(16'(count_q), WB_DAT_I, WB_SEL_I);
  assign wb_wr = wb_req & WB_WE_I;
  assign count_wr = wb_wr && WB_ADR_I == `ADGC_COUNT_OFS;
  // one command word acts on the whole group
  assign cmd = (wb_wr && WB_ADR_I == `ADGC_CMD_OFS && WB_SEL_I[0]) ? WB_DAT_I[2:0] : 3'h0;

  // Single-cycle ack; unmapped offsets are acked and read as zero
  always_ff @(posedge CLK)
  begin
    if (RST)
      ack_q <= 1'b0;
    else
      ack_q <= wb_req;
  end

  always_comb
  begin
    rd_d = 32'h0000_0000;
    case (WB_ADR_I)
      `ADGC_CTRL_OFS: rd_d = {16'h0000, ctrl_q};
      `ADGC_STAT_OFS: rd_d = {23'h0, act_lvl, drop_hold_q, trig_mode_q, state_q, run_q};
      `ADGC_COUNT_OFS: rd_d = {24'h0, count_q};
      `ADGC_GROUP_OFS: rd_d = {28'h0, group_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      WB_DAT_O <= 32'h0000_0000;
    else if (wb_req && !WB_WE_I)
      WB_DAT_O <= rd_d;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ctrl_q <= `ADGC_CTRL_RST;
      group_q <= `ADGC_GROUP_RST;
    end
    else if (wb_wr)
    begin
      if (WB_ADR_I == `ADGC_CTRL_OFS)
        ctrl_q <= adgc_merge(ctrl_q, WB_DAT_I, WB_SEL_I);
      if (WB_ADR_I == `ADGC_GROUP_OFS)
        group_q <= group_m[NMOD-1:0];
    end
  end

  // two-stage synchronisers; only the second stage feeds edge logic
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ext_s1_q <= 1'b1;
      ext_s2_q <= 1'b1;
      gate_s1_q <= 1'b0;
      gate_s2_q <= 1'b0;
    end
    else
    begin
      ext_s1_q <= DIO_I[`ADGC_DIG_START_BIT];
      ext_s2_q <= ext_s1_q;
      gate_s1_q <= GATE_I;
      gate_s2_q <= gate_s1_q;
    end
  end

  assign triggered = ctrl_q.ext_start_en | ctrl_q.gate_start_en;
  // gate line as start source when the input is not selected
  assign trig_lvl = ctrl_q.ext_start_en ? ext_s2_q : gate_s2_q;
  // input is active low unless inverted; gate is active high
  assign act_lvl = ctrl_q.ext_start_en ? (trig_lvl ^ ~ctrl_q.invert) : trig_lvl;
  assign act_rise = act_lvl & ~act_prev_q;
  assign act_fall = ~act_lvl & act_prev_q;
  assign preset_now = state_q == adgc_pkg::ADGC_RUN && |(PRESET_HIT & run_q);
  assign gate_ok = ~ctrl_q.gate_watch | gate_s2_q;

  always_ff @(posedge CLK)
  begin
    if (RST)
      act_prev_q <= 1'b0;
    else
      act_prev_q <= act_lvl;
  end

  always_comb
  begin
    state_d = state_q;
    run_d = run_q;
    case (state_q)
      adgc_pkg::ADGC_IDLE:
      begin
        // a triggered start only arms the monitor
        if (cmd.start && triggered)
          state_d = adgc_pkg::ADGC_ARMED;
        // optional erase before a direct start
        else if (cmd.start)
          state_d = ctrl_q.clear_before_start ? adgc_pkg::ADGC_CLEAR : adgc_pkg::ADGC_RUN;
      end
      adgc_pkg::ADGC_ARMED:
      begin
        if (cmd.stop)
          state_d = adgc_pkg::ADGC_IDLE;
        else if (act_rise)
          state_d = (ctrl_q.ext_start_en | ctrl_q.clear_before_start) ?
                    adgc_pkg::ADGC_CLEAR : adgc_pkg::ADGC_RUN;
      end
      adgc_pkg::ADGC_CLEAR:
        state_d = cmd.stop ? adgc_pkg::ADGC_IDLE : adgc_pkg::ADGC_RUN;
      adgc_pkg::ADGC_RUN:
      begin
        if (cmd.stop)
          state_d = adgc_pkg::ADGC_IDLE;
        // inactive level stops but stays armed
        else if (trig_mode_q && act_fall)
          state_d = adgc_pkg::ADGC_ARMED;
        // one preset stops every grouped module
        else if (preset_now && ctrl_q.any_preset_stops_all)
          state_d = adgc_pkg::ADGC_IDLE;
        else if ((run_q & ~PRESET_HIT) == '0)
          state_d = adgc_pkg::ADGC_IDLE;
        else
          run_d = run_q & ~PRESET_HIT;
      end
      default:
        state_d = adgc_pkg::ADGC_IDLE;
    endcase
    if (state_d == adgc_pkg::ADGC_RUN && state_q != adgc_pkg::ADGC_RUN)
      run_d = group_q;
    else if (state_d != adgc_pkg::ADGC_RUN)
      run_d = '0;
  end

  assign stop_evt = state_q == adgc_pkg::ADGC_RUN && state_d != adgc_pkg::ADGC_RUN;

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state_q <= adgc_pkg::ADGC_IDLE;
      run_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      run_q <= run_d;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      trig_mode_q <= 1'b0;
    else if (state_q == adgc_pkg::ADGC_IDLE && cmd.start)
      trig_mode_q <= triggered;
  end

  // software loads the value; a stop adds one unless written
  always_ff @(posedge CLK)
  begin
    if (RST)
      count_q <= `ADGC_COUNT_RST;
    else if (count_wr)
      count_q <= count_m[7:0];
    else if (stop_evt)
      count_q <= count_q + `ADGC_COUNT_STEP;
  end

  always_comb
  begin
    dio_val = 8'h00;
    // stop-count value takes the whole port
    if (ctrl_q.stop_count_mode)
      dio_val = count_q;
    // high while running; one bit per module
    else if (ctrl_q.status_mode)
      dio_val[NMOD-1:0] = run_q;
    if (ctrl_q.invert)
      dio_val = ~dio_val;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      DIO_O <= 8'h00;
      DIO_OE_N <= 8'hff;
    end
    else
    begin
      DIO_O <= dio_val;
      // open drain pulls low only; idle port is released
      if (!(ctrl_q.stop_count_mode || ctrl_q.status_mode))
        DIO_OE_N <= 8'hff;
      else if (ctrl_q.open_drain)
        DIO_OE_N <= dio_val | {3'h0, ctrl_q.ext_start_en, 4'h0};
      else
        DIO_OE_N <= {3'h0, ctrl_q.ext_start_en, 4'h0};
    end
  end

  // hold the gate low from the preset until the next start
  assign drop_hold_d = ctrl_q.gate_drop_on_preset &
                       (preset_now | (drop_hold_q & ~(state_d == adgc_pkg::ADGC_RUN &&
                                                      state_q != adgc_pkg::ADGC_RUN)));

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      drop_hold_q <= 1'b0;
      GATE_O <= 1'b0;
      GATE_OE_N <= 1'b1;
    end
    else
    begin
      drop_hold_q <= drop_hold_d;
      // drive high while running, unless a preset dropped it
      GATE_O <= ctrl_q.gate_high_when_on & (state_d == adgc_pkg::ADGC_RUN) & ~drop_hold_d;
      GATE_OE_N <= ~(ctrl_q.gate_high_when_on | drop_hold_d);
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      RUN <= '0;
      COUNT_EN <= '0;
      CLEAR <= '0;
    end
    else
    begin
      RUN <= run_d;
      // acquisition counts only while the gate is active
      COUNT_EN <= run_d & {NMOD{gate_ok}};
      // erase acts on the whole group
      CLEAR <= ((state_d == adgc_pkg::ADGC_CLEAR) || cmd.erase) ? group_q : '0;
    end
  end

  assign WB_ACK_O = ack_q;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sequence s_armed_edge;
    state_q == adgc_pkg::ADGC_ARMED && act_rise && !cmd.stop;
  endsequence

  sequence s_clear_then_run;
    CLEAR == group_q ##1 state_q == adgc_pkg::ADGC_RUN && RUN == group_q;
  endsequence

  a_status_bits: assert property (
    ctrl_q.status_mode && !ctrl_q.stop_count_mode && !ctrl_q.invert |=> DIO_O[NMOD-1:0] == $past(run_q))
    else $error("status bits do not follow running state");
  a_invert_count: assert property (
    ctrl_q.stop_count_mode && ctrl_q.invert |=> DIO_O == ~$past(count_q))
    else $error("inverted count not on port");
  a_count_port: assert property (
    ctrl_q.stop_count_mode && !ctrl_q.invert |=> DIO_O == $past(count_q))
    else $error("count value not on port");
  a_count_step: assert property (
    stop_evt && !count_wr |=> count_q == $past(count_q) + `ADGC_COUNT_STEP)
    else $error("count did not step at stop");
  a_open_drain: assert property (
    ctrl_q.open_drain |=> (DIO_O & ~DIO_OE_N) == 8'h00)
    else $error("open drain output driven high");
  a_arm_only: assert property (
    state_q == adgc_pkg::ADGC_IDLE && cmd.start && triggered |=> state_q == adgc_pkg::ADGC_ARMED && RUN == '0)
    else $error("triggered start did not arm");
  a_trig_clear: assert property (
    s_armed_edge and ctrl_q.ext_start_en && !wb_wr |=> s_clear_then_run)
    else $error("active edge did not clear then start");
  a_trig_stop: assert property (
    state_q == adgc_pkg::ADGC_RUN && trig_mode_q && act_fall && !cmd.stop |=> state_q == adgc_pkg::ADGC_ARMED)
    else $error("inactive level did not stop");
  a_stop_disarm: assert property (
    cmd.stop |=> state_q == adgc_pkg::ADGC_IDLE ##1 state_q != adgc_pkg::ADGC_RUN)
    else $error("stop did not end monitoring");
  a_count_gate: assert property (
    |COUNT_EN |-> $past(gate_ok))
    else $error("counting while gate inactive");
  a_gate_drop: assert property (
    preset_now && ctrl_q.gate_drop_on_preset |=> !GATE_O && !GATE_OE_N)
    else $error("gate not pulled low at preset");
  a_any_stops: assert property (
    preset_now && ctrl_q.any_preset_stops_all && !cmd.stop |=> run_q == '0 && RUN == '0)
    else $error("preset did not stop group");

endmodule

// ### tb/adgc_partner.sv
/*
  Far-side model: trigger source, gate controller and port pull-ups.
  Assumes the bench commands the trigger and gate levels.
*/
`timescale 1ns/1ps
module adgc_partner (
  input wire logic [7:0] dio_o,
  input wire logic [7:0] dio_oe_n,
  input wire logic gate_o,
  input wire logic gate_oe_n,
  input wire logic trig_lvl,
  input wire logic gate_lvl,
  output logic [7:0] dio_i,
  output logic gate_i
);
  // Released bits go to the pull-up level; the trigger source is open drain too
  assign dio_i = (dio_o | dio_oe_n) & {3'h7, trig_lvl, 4'hf};
  assign gate_i = gate_oe_n ? gate_lvl : gate_o;
endmodule

// ### tb/adgc_top_tb.sv
/*
  Self-checking bench for the digital I/O and gate control block.
  Assumes the partner model resolves the port and gate pins.
*/
`timescale 1ns/1ps
module adgc_top_tb;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, gate_i, gate_o, gate_oe_n;
  logic trig_lvl = 1'b1, gate_lvl = 1'b0;
  logic [7:0] adr = 8'h00, dio_i, dio_o, dio_oe_n, c;
  logic [31:0] wdat = 32'h0, rdat, r;
  logic [3:0] hit = 4'h0, run, cnt_en, clr, g, clr_last = 4'h0;
  int n_clr = 0, k, n_fail = 0, checked = 0, seed = 64;

  always #5 CLK = ~CLK;

  always @(posedge CLK)
  begin
    if (clr != 4'h0)
    begin
      clr_last <= clr;
      n_clr <= n_clr + 1;
    end
  end

  adgc_top DUT (
    .CLK(CLK), .RST(RST), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'h3), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .DIO_I(dio_i),
    .DIO_O(dio_o), .DIO_OE_N(dio_oe_n), .GATE_I(gate_i), .GATE_O(gate_o), .GATE_OE_N(gate_oe_n),
    .PRESET_HIT(hit), .RUN(run), .COUNT_EN(cnt_en), .CLEAR(clr)
  );

  adgc_partner PEER (
    .dio_o(dio_o), .dio_oe_n(dio_oe_n), .gate_o(gate_o), .gate_oe_n(gate_oe_n),
    .trig_lvl(trig_lvl), .gate_lvl(gate_lvl), .dio_i(dio_i), .gate_i(gate_i)
  );

  function automatic logic [7:0] oe_exp(input logic [7:0] v, input logic inv);
    return v ^ {8{inv}};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    checked++;
    if (seen !== expv)
    begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic wrap_up();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Waits a clock first so every request is launched just after an edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge CLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'($random(seed)), d};
    // Ack and read data are taken at the rising edge; only the watchdog ends a hang
    do
    begin
      @(posedge CLK);
    end
    while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wait_run(input logic [3:0] e);
    int n;
    n = 0;
    do
    begin
      @(negedge CLK);
      n++;
    end
    while (run !== e && n < 30);
    chk(32'(run), 32'(e));
  endtask

  task automatic settle();
    repeat (4) @(posedge CLK);
    @(negedge CLK);
  endtask

  task automatic trig(input logic lvl);
    @(posedge CLK);
    trig_lvl <= lvl;
  endtask

  initial
  begin
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    wb(1'b0, 8'h00, 16'h0);
    chk(r, 32'h0008);
    wb(1'b0, 8'h14, 16'h0);
    chk(r, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      c = 8'($random(seed));
      wb(1'b1, 8'h0c, {8'h0, c});
      wb(1'b1, 8'h00, 16'h000a);
      settle();
      chk(32'(dio_oe_n), 32'(oe_exp(c, 1'b0)));
      chk(32'(dio_o & ~dio_oe_n), 32'h0);
      wb(1'b1, 8'h00, 16'h000e);
      settle();
      chk(32'(dio_oe_n), 32'(oe_exp(c, 1'b1)));
      wb(1'b1, 8'h00, 16'h0002);
      settle();
      chk(32'({dio_oe_n, dio_o}), 32'(c));
    end
    g = 4'($random(seed)) | 4'h1;
    wb(1'b1, 8'h10, {12'h0, g});
    wb(1'b1, 8'h00, 16'h0009);
    wb(1'b1, 8'h04, 16'h0001);
    wait_run(g);
    settle();
    chk(32'(dio_i[3:0]), 32'(g));
    k = n_clr;
    wb(1'b1, 8'h04, 16'h0004);
    settle();
    chk(32'(n_clr - k), 32'h1);
    chk(32'(clr_last), 32'(g));
    wb(1'b1, 8'h04, 16'h0002);
    wait_run(4'h0);
    settle();
    chk(32'(dio_i[3:0]), 32'h0);
    wb(1'b0, 8'h0c, 16'h0);
    chk(r, 32'(8'(c + 8'h01)));
    wb(1'b1, 8'h10, 16'h000f);
    for (int i = 0; i < 2; i++)
    begin
      wb(1'b1, 8'h00, i ? 16'h0289 : 16'h0089);
      wb(1'b1, 8'h04, 16'h0001);
      wait_run(4'hf);
      @(posedge CLK);
      hit <= 4'h2;
      @(posedge CLK);
      hit <= 4'h0;
      wait_run(i ? 4'h0 : 4'hd);
      chk(32'({gate_oe_n, gate_o}), 32'h0);
      wb(1'b1, 8'h04, 16'h0002);
      wait_run(4'h0);
    end
    for (int v = 0; v < 2; v++)
    begin
      trig(v == 0);
      wb(1'b1, 8'h00, v ? 16'h001d : 16'h0019);
      wb(1'b1, 8'h04, 16'h0001);
      settle();
      chk(32'(run), 32'h0);
      wb(1'b0, 8'h08, 16'h0);
      chk(r, 32'h0000_0050);
      for (int i = 0; i < 2; i++)
      begin
        k = n_clr;
        trig(v != 0);
        wait_run(4'hf);
        chk(32'(n_clr - k), 32'h1);
        trig(v == 0);
        wait_run(4'h0);
      end
      wb(1'b1, 8'h04, 16'h0002);
      trig(v != 0);
      settle();
      chk(32'(run), 32'h0);
    end
    trig(1'b1);
    k = n_clr;
    wb(1'b1, 8'h00, 16'h0041);
    wb(1'b1, 8'h04, 16'h0001);
    wait_run(4'hf);
    chk(32'(n_clr - k), 32'h1);
    wb(1'b1, 8'h04, 16'h0002);
    wait_run(4'h0);
    wb(1'b1, 8'h00, 16'h0421);
    wb(1'b1, 8'h04, 16'h0001);
    settle();
    chk(32'(run), 32'h0);
    @(posedge CLK);
    gate_lvl <= 1'b1;
    wait_run(4'hf);
    chk(32'(cnt_en), 32'hf);
    wb(1'b1, 8'h04, 16'h0002);
    gate_lvl <= 1'b0;
    wait_run(4'h0);
    wb(1'b1, 8'h00, 16'h0401);
    wb(1'b1, 8'h04, 16'h0001);
    settle();
    chk(32'(cnt_en), 32'h0);
    wb(1'b1, 8'h00, 16'h0501);
    settle();
    chk(32'({gate_oe_n, gate_o}), 32'h1);
    chk(32'(cnt_en), 32'hf);
    wb(1'b1, 8'h04, 16'h0002);
    wait_run(4'h0);
    wrap_up();
  end

  // Whole run needs a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge CLK);
    n_fail++;
    wrap_up();
  end
endmodule
